/* src/rbs_top.sv */
// relay bank scanner control: relays, scanner, inputs, register port
//
// Notes on behaviour
// [RL1] sixteen relay outputs, contact or driver by build variant.
// [RL2] close/open changes only the named relays, others keep state.
// [RL3] one list command switches all listed relays in one update.
// [RL4] lists take single numbers or inclusive first:last ranges.
// [RL5] scan definition loads scanner relays, several per step for poles.
// [RL6] immediate initiate sets the initial position and enables scanning.
// [RL7] continuous setting one enables, zero disables; resets to zero.
// [RL8] each trigger while enabled advances the scanner one step.
// [RL9] each step opens previous relays before closing the next ones.
// [RL10] relays outside the scan list stay under individual control.
// [RL11] scan list holds sixteen relays per step, thirty-two steps.
// [RL12] save with argument zero writes the scan list to storage.
// [RL13] present input states readable in the condition register.
// [RL14] event register latches a bit per input that changed.
// [RL15] monitored input changes raise a service request.
// [RL16] relay enable output stays inactive during power-on setup.
// [RL17] relay outputs never pulse or glitch at power turn-on.
// [RL18] relays stay disabled until saved configuration is loaded.
// [RL19] rise and fall masks choose captured edges, sampled over 1 kHz.
// [RL20] enable bits gate events into the service request summary.
// [RL21] after the last step the next trigger returns to initial.
`timescale 1ns/10ps
module rbs_top import rbs_pkg::*; #(
  parameter int NR = RBS_NUM_RELAYS,
  parameter int NI = RBS_NUM_INPUTS,
  parameter int NS = RBS_SCAN_STEPS
) (
  // clock, reset, enable
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_in,
  input  wire logic                  ce_in,
  // register port
  input  wire logic [RBS_ADDR_W-1:0] addr_in,
  input  wire logic [RBS_DATA_W-1:0] wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [RBS_DATA_W-1:0] rdata_out,
  // relays and inputs
  output logic      [NR-1:0]         relay_out,
  output logic                       relay_en_out,
  input  wire logic [NI-1:0]         din_in,
  output logic                       srq_out,
  // scan list save to non-volatile storage
  output logic                       nvm_wr_out,
  output logic      [4:0]            nvm_addr_out,
  output logic      [NR-1:0]         nvm_data_out,
  output logic                       nvm_done_out
);
  localparam int AW = $clog2(NS);

  function automatic logic hit(input logic [RBS_ADDR_W-1:0] ofs);
    hit = (addr_in == ofs);
  endfunction : hit

  function automatic logic [NR-1:0] range_mask(
    input logic [RBS_RNG_NUM_W-1:0] first,
    input logic [RBS_RNG_NUM_W-1:0] last);
    for (int i = 0; i < NR; i++) begin
      range_mask[i] = (RBS_RNG_NUM_W'(i + 1) >= first) &&
                      (RBS_RNG_NUM_W'(i + 1) <= last);
    end
  endfunction : range_mask

  rbs_state_t        state_r;
  logic [NR-1:0]     manual_r;
  logic [NR-1:0]     members_r;
  logic [NR-1:0]     scan_act_r;
  logic [AW:0]       len_r;
  logic [AW-1:0]     pos_r;
  logic [AW-1:0]     save_idx_r;
  logic              at_init_r;
  logic              scan_en_r;
  logic              cont_r;
  logic              cfg_done_r;
  logic [NI-1:0]     ptr_r;
  logic [NI-1:0]     ntr_r;
  logic [NI-1:0]     qen_r;
  logic [NR-1:0]     step_mask;
  logic [NR-1:0]     save_mask;
  logic [NI-1:0]     cond;
  logic [NI-1:0]     qevent;
  logic [AW-1:0]     next_pos;
  logic              last_step;
  logic              scan_wr;
  logic              trig_hit;
  logic              save_hit;
  logic              list_clr;
  logic [NR-1:0]     rng_mask;
  logic [RBS_DATA_W-1:0] rdata_nxt;

  assign scan_wr  = wr_in && hit(RBS_OFS_SCAN) && (len_r < (AW+1)'(NS));
  assign trig_hit = wr_in && hit(RBS_OFS_TRIG);
  assign save_hit = wr_in && hit(RBS_OFS_SAVE) && (wdata_in == RBS_SAVE_ARG);
  assign list_clr = wr_in && hit(RBS_OFS_SCANCTL) &&
                    wdata_in[RBS_SCANCTL_CLR];
  assign rng_mask = range_mask(
    wdata_in[RBS_RNG_FIRST_LSB +: RBS_RNG_NUM_W],
    wdata_in[RBS_RNG_LAST_LSB +: RBS_RNG_NUM_W]);                // see [RL4]
  assign last_step = ({1'b0, pos_r} == (len_r - (AW+1)'(1)));
  assign next_pos  = at_init_r ? '0 : pos_r + AW'(1);

  rbs_scan_mem #(.WIDTH(NR), .DEPTH(NS), .AW(AW)) u_mem (
    .clk_sys_in  (clk_sys_in),
    .ce_in       (ce_in),
    .wr_in       (scan_wr),
    .waddr_in    (len_r[AW-1:0]),
    .wdata_in    (wdata_in[NR-1:0]),
    .raddr_a_in  (next_pos),
    .rdata_a_out (step_mask),
    .raddr_b_in  (save_idx_r),
    .rdata_b_out (save_mask)
  );

  rbs_input_monitor #(.N(NI)) u_mon (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .ce_in      (ce_in),
    .din_in     (din_in),
    .ptr_in     (ptr_r),
    .ntr_in     (ntr_r),
    .enable_in  (qen_r),
    .evt_clr_in (rd_in && hit(RBS_OFS_EVENT)),
    .cond_out   (cond),
    .event_out  (qevent),
    .srq_out    (srq_out)
  );

  // individual relay control: list and range writes land in one cycle
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      manual_r <= RBS_RELAY_RST;
    end else if (ce_in && wr_in) begin
      if (hit(RBS_OFS_CLOSE)) begin
        manual_r <= manual_r | wdata_in[NR-1:0];           // see [RL2] [RL3]
      end else if (hit(RBS_OFS_OPEN)) begin
        manual_r <= manual_r & ~wdata_in[NR-1:0];          // see [RL2] [RL3]
      end else if (hit(RBS_OFS_RANGE)) begin
        manual_r <= wdata_in[RBS_RNG_CLOSE_BIT] ? (manual_r | rng_mask)
                                                : (manual_r & ~rng_mask);
      end
    end
  end

  // scan list definition; members drop out of manual control
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      len_r     <= '0;
      members_r <= '0;
    end else if (ce_in) begin
      if (list_clr) begin
        len_r     <= '0;
        members_r <= '0;
      end else if (scan_wr) begin
        len_r     <= len_r + (AW+1)'(1);                   // see [RL5] [RL11]
        members_r <= members_r | wdata_in[NR-1:0];
      end
    end
  end

  // scan enable and continuous setting
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cont_r    <= RBS_CONT_RST;
      scan_en_r <= 1'b0;
    end else if (ce_in) begin
      if (list_clr) begin
        scan_en_r <= 1'b0;
      end else if (wr_in && hit(RBS_OFS_INIT)) begin
        cont_r    <= wdata_in[RBS_INIT_CONT_BIT];          // see [RL7]
        scan_en_r <= wdata_in[RBS_INIT_IMM_BIT] ||
                     wdata_in[RBS_INIT_CONT_BIT];          // see [RL6] [RL7]
      end
    end
  end

  // scanner and save sequencer; busy states ignore new triggers
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_r    <= RBS_ST_IDLE;
      scan_act_r <= '0;
      pos_r      <= '0;
      at_init_r  <= 1'b1;
      save_idx_r <= '0;
    end else if (ce_in) begin
      case (state_r)
        RBS_ST_IDLE: begin
          if (list_clr || (wr_in && hit(RBS_OFS_INIT) &&
                           wdata_in[RBS_INIT_IMM_BIT])) begin
            scan_act_r <= '0;                              // see [RL6]
            at_init_r  <= 1'b1;
          end else if (save_hit) begin
            save_idx_r <= '0;
            state_r    <= RBS_ST_SAVE;                     // see [RL12]
          end else if (trig_hit && scan_en_r && len_r != '0) begin
            scan_act_r <= '0;                              // see [RL8] [RL9]
            state_r    <= RBS_ST_BREAK;
          end
        end
        RBS_ST_BREAK: begin
          state_r <= RBS_ST_MAKE;
        end
        RBS_ST_MAKE: begin
          if (!at_init_r && last_step) begin
            at_init_r <= 1'b1;                             // see [RL21]
          end else begin
            at_init_r  <= 1'b0;
            pos_r      <= next_pos;
            scan_act_r <= step_mask;                       // see [RL9]
          end
          state_r <= RBS_ST_IDLE;
        end
        RBS_ST_SAVE: begin
          if ({1'b0, save_idx_r} >= len_r ||
              save_idx_r == AW'(NS - 1)) begin
            state_r <= RBS_ST_IDLE;
          end else begin
            save_idx_r <= save_idx_r + AW'(1);
          end
        end
        default: begin
          state_r <= RBS_ST_IDLE;
        end
      endcase
    end
  end

  // storage write strobes, one word per cycle; done pulses after the last word, or with it when all 32 steps are saved
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      nvm_wr_out   <= 1'b0;
      nvm_addr_out <= '0;
      nvm_data_out <= '0;
      nvm_done_out <= 1'b0;
    end else if (ce_in) begin
      nvm_wr_out   <= (state_r == RBS_ST_SAVE) &&
                      ({1'b0, save_idx_r} < len_r);        // see [RL12]
      nvm_addr_out <= 5'(save_idx_r);
      nvm_data_out <= save_mask;
      nvm_done_out <= (state_r == RBS_ST_SAVE) &&
                      (({1'b0, save_idx_r} >= len_r) ||
                       save_idx_r == AW'(NS - 1));
    end
  end

  // outputs held off until software has restored the saved setup
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_done_r   <= 1'b0;
      relay_en_out <= 1'b0;
      relay_out    <= RBS_RELAY_RST;                       // see [RL17]
    end else if (ce_in) begin
      if (wr_in && hit(RBS_OFS_CFGDONE)) begin
        cfg_done_r <= wdata_in[RBS_CFGDONE_BIT];
      end
      relay_en_out <= cfg_done_r;                          // see [RL16]
      relay_out    <= cfg_done_r ?
                      ((manual_r & ~members_r) | (scan_act_r & members_r))
                      : RBS_RELAY_RST;                     // see [RL1] [RL10] [RL18]
    end
  end

  // questionable masks
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ptr_r <= ~RBS_MASK_RST;
      ntr_r <= RBS_MASK_RST;
      qen_r <= RBS_MASK_RST;
    end else if (ce_in && wr_in) begin
      if (hit(RBS_OFS_PTR))    ptr_r <= wdata_in[NI-1:0];  // see [RL19]
      if (hit(RBS_OFS_NTR))    ntr_r <= wdata_in[NI-1:0];  // see [RL19]
      if (hit(RBS_OFS_ENABLE)) qen_r <= wdata_in[NI-1:0];  // see [RL20]
    end
  end

  always_comb begin
    rdata_nxt = '0;
    case (addr_in)
      RBS_OFS_CLOSE, RBS_OFS_OPEN: rdata_nxt[NR-1:0] = manual_r;
      RBS_OFS_STATE:   rdata_nxt[NR-1:0] = relay_out;
      RBS_OFS_SCAN:    rdata_nxt[NR-1:0] = members_r;
      RBS_OFS_SCANCTL: rdata_nxt[AW:0] = len_r;
      RBS_OFS_INIT:    rdata_nxt[RBS_INIT_CONT_BIT] = cont_r;
      RBS_OFS_CFGDONE: rdata_nxt[RBS_CFGDONE_BIT] = cfg_done_r;
      RBS_OFS_COND:    rdata_nxt[NI-1:0] = cond;           // see [RL13]
      RBS_OFS_EVENT:   rdata_nxt[NI-1:0] = qevent;
      RBS_OFS_ENABLE:  rdata_nxt[NI-1:0] = qen_r;
      RBS_OFS_PTR:     rdata_nxt[NI-1:0] = ptr_r;
      RBS_OFS_NTR:     rdata_nxt[NI-1:0] = ntr_r;
      RBS_OFS_SCANST:  rdata_nxt = {20'h0, state_r, scan_en_r,
                                    at_init_r, 1'b0, pos_r};
      default:         rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= '0;
    end else if (ce_in) begin
      rdata_out <= rd_in ? rdata_nxt : '0;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in || !ce_in);

  sequence s_trig_taken;
    (state_r == RBS_ST_IDLE) && trig_hit && scan_en_r && (len_r != '0) &&
    !list_clr && !save_hit && !(wr_in && addr_in == RBS_OFS_INIT);
  endsequence
  sequence s_break_make;
    (state_r == RBS_ST_BREAK && scan_act_r == '0)
    ##1 (state_r == RBS_ST_MAKE && scan_act_r == '0)
    ##1 (state_r == RBS_ST_IDLE);
  endsequence

  a_relay_held_off: assert property (                      // see [RL18]
    !relay_en_out |-> (relay_out == '0))
    else $error("relays driven before configuration loaded");
  a_close_named: assert property (                         // see [RL2]
    (wr_in && addr_in == RBS_OFS_CLOSE) |=>
      (manual_r == ($past(manual_r) | $past(wdata_in[NR-1:0]))))
    else $error("close changed relays not named");
  a_range_close: assert property (                         // see [RL4]
    (wr_in && addr_in == RBS_OFS_RANGE && wdata_in[RBS_RNG_CLOSE_BIT]) |=>
      (manual_r == ($past(manual_r) | $past(rng_mask))))
    else $error("range close wrong");
  a_break_before: assert property (                        // see [RL9]
    s_trig_taken |=> s_break_make)
    else $error("scanner step not break before make");
  a_trig_ignored: assert property (                        // see [RL8]
    ((state_r == RBS_ST_IDLE) && trig_hit && !scan_en_r && !list_clr &&
     !save_hit && !(wr_in && addr_in == RBS_OFS_INIT))
      |=> (state_r == RBS_ST_IDLE) && $stable(scan_act_r))
    else $error("trigger acted while scanning disabled");
  a_wrap_init: assert property (                           // see [RL21]
    (state_r == RBS_ST_MAKE && !at_init_r && last_step) |=>
      (at_init_r && scan_act_r == '0))
    else $error("scanner did not return to initial position");
  a_manual_free: assert property (                         // see [RL10]
    cfg_done_r |=> ((relay_out & ~$past(members_r)) ==
                    ($past(manual_r) & ~$past(members_r))))
    else $error("non-scan relay not under manual control");
  a_imm_init: assert property (                            // see [RL6]
    (state_r == RBS_ST_IDLE && wr_in && addr_in == RBS_OFS_INIT &&
     wdata_in[RBS_INIT_IMM_BIT] && !list_clr) |=>
      (scan_en_r && at_init_r && scan_act_r == '0))
    else $error("initiate did not set initial position");
  a_cont_off: assert property (                            // see [RL7]
    (wr_in && addr_in == RBS_OFS_INIT && wdata_in[1:0] == 2'h0) |=>
      (!scan_en_r && !cont_r))
    else $error("continuous zero did not disable scanning");
  a_list_cap: assert property (                            // see [RL11]
    len_r <= (AW+1)'(NS))
    else $error("scan list over capacity");
  a_save_start: assert property (                          // see [RL12]
    (state_r == RBS_ST_IDLE && save_hit && !list_clr &&
     !(wr_in && addr_in == RBS_OFS_INIT) && len_r != '0)
      |=> ##1 nvm_wr_out && nvm_addr_out == 5'h00)
    else $error("save did not write first step");
endmodule : rbs_top

/* common/rbs_pkg.sv */
// constants and types for the relay bank scanner control block
package rbs_pkg;
  localparam int RBS_NUM_RELAYS = 16;
  localparam int RBS_NUM_INPUTS = 8;
  localparam int RBS_SCAN_STEPS = 32;
  localparam int RBS_ADDR_W     = 8;
  localparam int RBS_DATA_W     = 32;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] RBS_OFS_CLOSE   = 8'h00;
  localparam logic [7:0] RBS_OFS_OPEN    = 8'h04;
  localparam logic [7:0] RBS_OFS_RANGE   = 8'h08;
  localparam logic [7:0] RBS_OFS_STATE   = 8'h0c;
  localparam logic [7:0] RBS_OFS_SCAN    = 8'h10;
  localparam logic [7:0] RBS_OFS_SCANCTL = 8'h14;
  localparam logic [7:0] RBS_OFS_INIT    = 8'h18;
  localparam logic [7:0] RBS_OFS_TRIG    = 8'h1c;
  localparam logic [7:0] RBS_OFS_SAVE    = 8'h20;
  localparam logic [7:0] RBS_OFS_CFGDONE = 8'h24;
  localparam logic [7:0] RBS_OFS_COND    = 8'h28;
  localparam logic [7:0] RBS_OFS_EVENT   = 8'h2c;
  localparam logic [7:0] RBS_OFS_ENABLE  = 8'h30;
  localparam logic [7:0] RBS_OFS_PTR     = 8'h34;
  localparam logic [7:0] RBS_OFS_NTR     = 8'h38;
  localparam logic [7:0] RBS_OFS_SCANST  = 8'h3c;

  // field positions
  localparam int RBS_RNG_FIRST_LSB = 0;
  localparam int RBS_RNG_LAST_LSB  = 8;
  localparam int RBS_RNG_NUM_W     = 5;
  localparam int RBS_RNG_CLOSE_BIT = 16;
  localparam int RBS_INIT_IMM_BIT  = 0;
  localparam int RBS_INIT_CONT_BIT = 1;
  localparam int RBS_SCANCTL_CLR   = 0;
  localparam int RBS_CFGDONE_BIT   = 0;

  // reset values and the save command argument
  localparam logic        RBS_CONT_RST  = 1'b0;
  localparam logic [15:0] RBS_RELAY_RST = 16'h0000;
  localparam logic [7:0]  RBS_MASK_RST  = 8'h00;
  localparam logic [31:0] RBS_SAVE_ARG  = 32'h0000_0000;

  typedef enum logic [3:0] {
    RBS_ST_IDLE  = 4'b0001,
    RBS_ST_BREAK = 4'b0010,
    RBS_ST_MAKE  = 4'b0100,
    RBS_ST_SAVE  = 4'b1000
  } rbs_state_t;
endpackage : rbs_pkg

/* src/rbs_scan_mem.sv */
// scan list storage: one relay mask per step, two read ports
`timescale 1ns/10ps
module rbs_scan_mem import rbs_pkg::*; #(
  parameter int WIDTH = RBS_NUM_RELAYS,
  parameter int DEPTH = RBS_SCAN_STEPS,
  parameter int AW    = $clog2(DEPTH)
) (
  // clocking
  input  wire logic             clk_sys_in,
  input  wire logic             ce_in,
  // write port
  input  wire logic             wr_in,
  input  wire logic [AW-1:0]    waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  // read ports
  input  wire logic [AW-1:0]    raddr_a_in,
  output logic      [WIDTH-1:0] rdata_a_out,
  input  wire logic [AW-1:0]    raddr_b_in,
  output logic      [WIDTH-1:0] rdata_b_out
);
  // no reset: contents only matter below the list length
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (ce_in && wr_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  assign rdata_a_out = mem[raddr_a_in];
  assign rdata_b_out = mem[raddr_b_in];
endmodule : rbs_scan_mem

/* src/rbs_input_monitor.sv */
// digital input condition, transition filter, event latch and summary
`timescale 1ns/10ps
module rbs_input_monitor import rbs_pkg::*; #(
  parameter int N = RBS_NUM_INPUTS
) (
  // clocking
  input  wire logic         clk_sys_in,
  input  wire logic         reset_in,
  input  wire logic         ce_in,
  // inputs and masks
  input  wire logic [N-1:0] din_in,
  input  wire logic [N-1:0] ptr_in,
  input  wire logic [N-1:0] ntr_in,
  input  wire logic [N-1:0] enable_in,
  input  wire logic         evt_clr_in,
  // status
  output logic      [N-1:0] cond_out,
  output logic      [N-1:0] event_out,
  output logic              srq_out
);
  logic         primed_r;
  logic [N-1:0] set_nxt;

  // sampled every clock, far above the 1 kHz floor
  always_comb begin
    set_nxt = primed_r ?
              ((din_in & ~cond_out & ptr_in) | (~din_in & cond_out & ntr_in))
              : '0;                                      // see [RL19]
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cond_out <= '0;
      primed_r <= 1'b0;
    end else if (ce_in) begin
      cond_out <= din_in;                                // see [RL13]
      primed_r <= 1'b1;
    end
  end

  // set wins over a clear-on-read in the same cycle
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      event_out <= '0;
    end else if (ce_in) begin
      event_out <= (evt_clr_in ? '0 : event_out) | set_nxt; // see [RL14]
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      srq_out <= 1'b0;
    end else if (ce_in) begin
      srq_out <= |(event_out & enable_in);               // see [RL15] [RL20]
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in || !ce_in);

  a_event_latch: assert property (                        // see [RL14]
    (set_nxt != '0) |=> ((event_out & $past(set_nxt)) == $past(set_nxt)))
    else $error("changed input not latched in event register");
  a_srq_gate: assert property (                           // see [RL20]
    ##1 (srq_out == |($past(event_out) & $past(enable_in))))
    else $error("service request does not follow enabled events");
endmodule : rbs_input_monitor

/* verification/rbs_cmd_model.sv */
// command source model: issues register writes and reads
`timescale 1ns/10ps
module rbs_cmd_model import rbs_pkg::*; (
  // clock
  input  wire logic                  clk_sys_in,
  // register port
  input  wire logic [RBS_DATA_W-1:0] rdata_in,
  output logic      [RBS_ADDR_W-1:0] addr_out,
  output logic      [RBS_DATA_W-1:0] wdata_out,
  output logic                       wr_out,
  output logic                       rd_out
);
  initial begin
    addr_out  = 8'h00;
    wdata_out = 32'h0000_0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // returns at the edge that takes the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_sys_in);
    wr_out    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_sys_in);
    rd_out   <= 1'b0;
    #1 d = rdata_in;
  endtask : rd
endmodule : rbs_cmd_model

/* verification/test_relay_bank_scanner_control.sv */
// self-checking bench for the relay bank scanner control block
`timescale 1ns/10ps
module test_relay_bank_scanner_control import rbs_pkg::*; ();
  logic        clk_sys_in;
  logic        reset_in;
  logic [7:0]  din;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] v;
  logic        wr;
  logic        rd;
  logic [15:0] relays;
  logic        relay_en;
  logic        srq;
  logic        nvm_wr;
  logic        nvm_done;
  logic [4:0]  nvm_addr;
  logic [15:0] nvm_data;
  logic [15:0] steps [2] = '{16'h0003, 16'h000c};
  int          bad_count = 0;
  int          checks_done = 0;

  rbs_cmd_model cmd (.clk_sys_in(clk_sys_in), .rdata_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  rbs_top uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .relay_out(relays), .relay_en_out(relay_en),
    .din_in(din), .srq_out(srq), .nvm_wr_out(nvm_wr),
    .nvm_addr_out(nvm_addr), .nvm_data_out(nvm_data),
    .nvm_done_out(nvm_done));

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string m);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc

  // busy lasts two cycles, so five leaves the step settled
  task automatic trig(input logic [15:0] exp);
    cmd.wr(RBS_OFS_TRIG, 32'h0);
    cyc(5);
    chk(relays, exp, "scan step");
  endtask : trig

  task automatic t_power();
    cmd.rd(RBS_OFS_INIT, v);
    chk(v, 32'h0, "continuous default");
    cmd.wr(RBS_OFS_CLOSE, 32'h5);
    cyc(3);
    chk(relays, 16'h0, "relays before load");
    chk(relay_en, 1'b0, "enable before load");
    cmd.wr(RBS_OFS_CFGDONE, 32'h1);
    cyc(3);
    chk(relay_en, 1'b1, "enable after load");
    chk(relays, 16'h5, "relays after load");
    $display("test power done");
  endtask : t_power

  task automatic t_manual();
    cmd.wr(RBS_OFS_OPEN, 32'h1);
    cyc(2);
    chk(relays, 16'h4, "open one");
    cmd.wr(RBS_OFS_RANGE, 32'h0001_0d0b);
    cyc(2);
    chk(relays, 16'h1c04, "range close");
    cmd.wr(RBS_OFS_RANGE, 32'h0000_0c0c);
    cmd.rd(RBS_OFS_STATE, v);
    chk(v, 32'h1404, "state read");
    cmd.wr(RBS_OFS_OPEN, 32'hffff);
    cmd.wr(RBS_OFS_CLOSE, 32'h8000);
    $display("test manual done");
  endtask : t_manual

  task automatic t_scan();
    logic brk;
    cmd.wr(RBS_OFS_SCAN, 32'h3);
    cmd.wr(RBS_OFS_SCAN, 32'hc);
    cmd.wr(RBS_OFS_INIT, 32'h1);
    cyc(3);
    chk(relays, 16'h8000, "initial position");
    trig(16'h8003);
    cmd.wr(RBS_OFS_TRIG, 32'h0);
    brk = 1'b0;
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      if (relays[3:0] === 4'h0) brk = 1'b1;
    end
    chk(brk, 1'b1, "break phase");
    chk(relays, 16'h800c, "second step");
    cmd.wr(RBS_OFS_CLOSE, 32'h4000);
    cmd.wr(RBS_OFS_OPEN, 32'h8000);
    cyc(2);
    chk(relays, 16'h400c, "manual beside scan");
    trig(16'h4000);
    trig(16'h4003);
    cmd.wr(RBS_OFS_INIT, 32'h0);
    trig(16'h4003);
    cmd.wr(RBS_OFS_INIT, 32'h2);
    trig(16'h400c);
    $display("test scan done");
  endtask : t_scan

  task automatic t_save(input logic [31:0] arg, input int exp_n);
    int n;
    int d;
    n = 0;
    d = 0;
    cmd.wr(RBS_OFS_SAVE, arg);
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      if (nvm_wr === 1'b1) begin
        chk(nvm_addr, n, "saved step index");
        chk(nvm_data, steps[n], "saved step mask");
        n++;
      end
      if (nvm_done === 1'b1) d++;
    end
    chk(n, exp_n, "saved words");
    chk(d, (exp_n > 0), "save end pulse");
    $display("test save done");
  endtask : t_save

  task automatic t_depth();
    cmd.wr(RBS_OFS_SCANCTL, 32'h1);
    for (int i = 0; i < 33; i++) cmd.wr(RBS_OFS_SCAN, 32'hffff);
    cmd.rd(RBS_OFS_SCANCTL, v);
    chk(v, 32'h20, "list length");
    $display("test depth done");
  endtask : t_depth

  task automatic t_inputs();
    cmd.wr(RBS_OFS_ENABLE, 32'hff);
    @(posedge clk_sys_in);
    din <= 8'h81;
    cyc(4);
    chk(srq, 1'b1, "request raised");
    cmd.rd(RBS_OFS_COND, v);
    chk(v, 32'h81, "condition");
    cmd.rd(RBS_OFS_EVENT, v);
    chk(v, 32'h81, "rising events");
    cyc(3);
    chk(srq, 1'b0, "request cleared");
    cmd.wr(RBS_OFS_ENABLE, 32'h80);
    cmd.wr(RBS_OFS_PTR, 32'h0);
    cmd.wr(RBS_OFS_NTR, 32'h1);
    @(posedge clk_sys_in);
    din <= 8'h00;
    cyc(4);
    chk(srq, 1'b0, "masked event");
    cmd.rd(RBS_OFS_EVENT, v);
    chk(v, 32'h1, "falling filter");
    $display("test inputs done");
  endtask : t_inputs

  initial begin
    reset_in = 1'b1;
    din      = 8'h00;
    repeat (9) @(posedge clk_sys_in);
    #1;
    chk(relays, 16'h0, "relays in reset");
    chk(relay_en, 1'b0, "enable in reset");
    @(posedge clk_sys_in);
    reset_in <= 1'b0;
    cyc(2);
    t_power();
    t_manual();
    t_scan();
    t_save(32'h1, 0);
    t_save(RBS_SAVE_ARG, 2);
    t_depth();
    t_inputs();
    summarize();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    summarize();
  end
endmodule : test_relay_bank_scanner_control
